/* File: core/psl_pkg.sv */
`default_nettype none
package psl_pkg;
  // ***************************************
  // Geometry
  // ***************************************
  localparam int NUM_PORTS = 5;
  localparam int IND_PER_PORT = 3;
  localparam int NUM_IND = 15;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ***************************************
  // Register offsets
  // ***************************************
  localparam logic [7:0] ADDR_CONFIG = 8'h0f;
  localparam logic [7:0] ADDR_FUNC0 = 8'h10;
  localparam logic [7:0] ADDR_FUNC1 = 8'h12;
  localparam logic [7:0] ADDR_FMAP = 8'h14;
  localparam logic [7:0] ADDR_EMAP = 8'h16;
  localparam logic [7:0] ADDR_MODE0 = 8'h18;
  localparam logic [7:0] ADDR_MODE1 = 8'h1a;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_STRAPS = 8'h1e;

  // ***************************************
  // Field positions and reset values
  // ***************************************
  localparam int CFG_SERIAL_BIT = 0;
  localparam int CFG_SWSEL_BIT = 1;
  localparam int CFG_LIVE_BIT = 7;
  localparam logic [7:0] CONFIG_RST = 8'h80;
  localparam logic [15:0] FUNC_RST = 16'h0000;
  localparam logic [15:0] FMAP_RST = 16'h0000;
  localparam logic [15:0] EMAP_RST = 16'h001f;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [3:0] STRAP_RST = 4'hf;

  // ***************************************
  // Display function codes and strap sets
  // ***************************************
  localparam logic [3:0] FN_LINK = 4'h0;
  localparam logic [3:0] FN_ACT = 4'h1;
  localparam logic [3:0] FN_LINK_ACT = 4'h2;
  localparam logic [3:0] FN_DUPLEX = 4'h3;
  localparam logic [3:0] FN_SPEED100 = 4'h4;
  localparam logic [3:0] FN_SPEED10 = 4'h5;
  localparam logic [15:0] STRAP_SET0 = 16'h001c;
  localparam logic [15:0] STRAP_SET1 = 16'h0013;
  localparam logic [15:0] STRAP_SET2 = 16'h002c;
  localparam logic [15:0] STRAP_SET3 = 16'h000b;

  // ***************************************
  // Timing
  // ***************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCLK_PERIOD_NS = 800;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int BLINK_HALF_NS = 50000000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;

  // ***************************************
  // Types
  // ***************************************
  typedef enum logic [1:0] {
    MODE_AUTO = 2'b00,
    MODE_OFF = 2'b01,
    MODE_ON = 2'b10,
    MODE_BLINK = 2'b11
  } psl_mode_t;

  typedef enum logic {
    SH_LOW = 1'b0,
    SH_HIGH = 1'b1
  } psl_sclk_state_t;

  typedef struct packed {
    logic link;
    logic duplex;
    logic speed100;
    logic activity;
  } psl_port_stat_t;

  typedef struct packed {
    logic mgmt_sel;
    logic hw_fwd;
    logic freq_hi;
    logic freq_lo;
  } psl_strap_t;

  typedef struct packed {
    logic [2:0] vld;
    logic [2:0][3:0] code;
  } psl_fsel_t;
endpackage : psl_pkg
`default_nettype wire

/* File: core/psl_top.sv */
// Function
// - Fifteen indicator outputs, three per port for five ports.
// - Pin positions fixed per port even when ports are disabled.
// - Functions come from the strap value or the function registers.
// - Port map bit picks function register 0 or 1 per port.
// - Only enabled ports show status; disabled ports stay off.
// - At most three functions per port, always three positions.
// - Stream goes port 4 down to port 0, bits A then B then C.
// - Mode maps force blink, on, off or automatic per indicator.
// - Live-update bit set follows status, cleared freezes; set after reset.
// - Link, duplex, speed active low; activity shown by blinking.
// - Parallel and serial outputs share one status stream.
// - Parallel mode shifts and holds bits internally, drives pins directly.
// - Serial mode uses only a data line and a shift clock.
// - Four pins sampled as straps during reset, then outputs.
// - Strap high gives active-low output; strap low gives active-high.
// - Port 4,3,2,1 C pins latch mgmt select, forwarding, freq hi, lo.
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module psl_top
  import psl_pkg::*;
#(
  parameter int BLINK_HALF = BLINK_HALF_CYC,
  parameter int SCLK_HALF = SCLK_HALF_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire psl_port_stat_t [NUM_PORTS-1:0] i_port_stat,
  input wire logic [1:0] i_indicator_function_strap,
  input wire logic [NUM_IND-1:0] i_ind_pin,
  output logic [NUM_IND-1:0] o_ind,
  output logic [NUM_IND-1:0] o_ind_oe,
  output logic o_serial_indicator_data,
  output logic o_serial_indicator_clock,
  output psl_strap_t o_strap,
  output logic [1:0] o_indicator_function_strap
);

  // ***************************************
  // Elaboration checks
  // ***************************************
  if (BLINK_HALF < 1 || BLINK_HALF >= (1 << 24)) begin : g_bad_blink
    $error("blink half period out of range");
  end
  if (SCLK_HALF < 1 || SCLK_HALF >= 256) begin : g_bad_sclk
    $error("shift clock half period out of range");
  end

  // Indices of the dual-purpose C pins of ports 4..1
  localparam int DUAL_P4 = 4 * IND_PER_PORT;
  localparam int DUAL_P3 = 3 * IND_PER_PORT;
  localparam int DUAL_P2 = 2 * IND_PER_PORT;
  localparam int DUAL_P1 = 1 * IND_PER_PORT;

  // ***************************************
  // Functions
  // ***************************************
  function automatic psl_fsel_t pick3(input logic [15:0] map);
    psl_fsel_t r;
    int n;
    r = '0;
    n = 0;
    for (int b = 0; b < 16; b++) begin
      if (map[b] && n < IND_PER_PORT) begin
        r.code[n] = 4'(b);
        r.vld[n] = 1'b1;
        n++;
      end
    end
    return r;
  endfunction : pick3

  function automatic logic fn_eval(input logic [3:0] code, input psl_port_stat_t s, input logic blink);
    logic r;
    case (code)
      FN_LINK: r = s.link;
      FN_ACT: r = s.activity & blink;
      FN_LINK_ACT: r = s.link & ~(s.activity & blink);
      FN_DUPLEX: r = s.link & s.duplex;
      FN_SPEED100: r = s.link & s.speed100;
      FN_SPEED10: r = s.link & ~s.speed100;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : fn_eval

  // ***************************************
  // Strap sampling
  // ***************************************
  // Three stages; first stage feeds only the second
  logic [5:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_val_r, pin_val_nxt;
  psl_strap_t strap_r, strap_nxt;
  logic [1:0] fstrap_r, fstrap_nxt;
  logic [5:0] pin_raw;

  assign pin_raw = {i_indicator_function_strap, i_ind_pin[DUAL_P4], i_ind_pin[DUAL_P3],
                    i_ind_pin[DUAL_P2], i_ind_pin[DUAL_P1]};

  always_comb begin
    pin_val_nxt = pin_val_r;
    for (int i = 0; i < 6; i++) begin
      if (pin_s2_r[i] == pin_s3_r[i]) begin
        pin_val_nxt[i] = pin_s3_r[i];
      end
    end
    strap_nxt = strap_r;
    fstrap_nxt = fstrap_r;
    // Caught on every edge while reset is held, so the last sample wins
    if (i_rst) begin
      strap_nxt = psl_strap_t'(pin_val_r[3:0]);
      fstrap_nxt = pin_val_r[5:4];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    pin_s1_r <= pin_raw;
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
    pin_val_r <= pin_val_nxt;
    strap_r <= strap_nxt;
    fstrap_r <= fstrap_nxt;
  end

  // ***************************************
  // Register file
  // ***************************************
  logic [7:0] cfg_r, cfg_nxt;
  logic [15:0] func0_r, func0_nxt, func1_r, func1_nxt, fmap_r, fmap_nxt;
  logic [15:0] emap_r, emap_nxt, mode0_r, mode0_nxt, mode1_r, mode1_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  logic [NUM_IND-1:0] stat_r, stat_nxt;

  always_comb begin
    cfg_nxt = cfg_r;
    func0_nxt = func0_r;
    func1_nxt = func1_r;
    fmap_nxt = fmap_r;
    emap_nxt = emap_r;
    mode0_nxt = mode0_r;
    mode1_nxt = mode1_r;
    rdata_nxt = '0;
    if (i_wr) begin
      case (i_addr)
        ADDR_CONFIG: cfg_nxt = i_wdata[7:0];
        ADDR_FUNC0: func0_nxt = i_wdata;
        ADDR_FUNC1: func1_nxt = i_wdata;
        ADDR_FMAP: fmap_nxt = i_wdata;
        ADDR_EMAP: emap_nxt = i_wdata;
        ADDR_MODE0: mode0_nxt = i_wdata;
        ADDR_MODE1: mode1_nxt = i_wdata;
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        ADDR_CONFIG: rdata_nxt = {8'h00, cfg_r};
        ADDR_FUNC0: rdata_nxt = func0_r;
        ADDR_FUNC1: rdata_nxt = func1_r;
        ADDR_FMAP: rdata_nxt = fmap_r;
        ADDR_EMAP: rdata_nxt = emap_r;
        ADDR_MODE0: rdata_nxt = mode0_r;
        ADDR_MODE1: rdata_nxt = mode1_r;
        ADDR_STATUS: rdata_nxt = {1'b0, stat_r};
        ADDR_STRAPS: rdata_nxt = {10'h000, fstrap_r, strap_r};
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cfg_r <= CONFIG_RST;
      func0_r <= FUNC_RST;
      func1_r <= FUNC_RST;
      fmap_r <= FMAP_RST;
      emap_r <= EMAP_RST;
      mode0_r <= MODE_RST;
      mode1_r <= MODE_RST;
      o_rdata <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      func0_r <= func0_nxt;
      func1_r <= func1_nxt;
      fmap_r <= fmap_nxt;
      emap_r <= emap_nxt;
      mode0_r <= mode0_nxt;
      mode1_r <= mode1_nxt;
      o_rdata <= rdata_nxt;
    end
  end

  // ***************************************
  // Blink timer
  // ***************************************
  logic [23:0] blink_cnt_r, blink_cnt_nxt;
  logic blink_r, blink_nxt;

  always_comb begin
    blink_cnt_nxt = blink_cnt_r + 24'h000001;
    blink_nxt = blink_r;
    if (blink_cnt_r == 24'(BLINK_HALF - 1)) begin
      blink_cnt_nxt = '0;
      blink_nxt = ~blink_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      blink_cnt_r <= '0;
      blink_r <= 1'b0;
    end else begin
      blink_cnt_r <= blink_cnt_nxt;
      blink_r <= blink_nxt;
    end
  end

  // ***************************************
  // Status composition
  // ***************************************
  // Bit p*3+2 is port p A, bit p*3 is port p C
  logic [15:0] strap_map;

  always_comb begin
    psl_fsel_t sel;
    psl_mode_t m;
    logic on;
    int k;
    sel = '0;
    m = MODE_AUTO;
    on = 1'b0;
    k = 0;
    stat_nxt = stat_r;
    case (fstrap_r)
      2'b00: strap_map = STRAP_SET0;
      2'b01: strap_map = STRAP_SET1;
      2'b10: strap_map = STRAP_SET2;
      default: strap_map = STRAP_SET3;
    endcase
    // Cleared live bit holds the last picture, blink phase included
    if (cfg_r[CFG_LIVE_BIT]) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (cfg_r[CFG_SWSEL_BIT]) begin
          sel = pick3(fmap_r[p] ? func1_r : func0_r);
        end else begin
          sel = pick3(strap_map);
        end
        for (int l = 0; l < IND_PER_PORT; l++) begin
          k = p * IND_PER_PORT + (IND_PER_PORT - 1 - l);
          m = psl_mode_t'({mode1_r[k], mode0_r[k]});
          case (m)
            MODE_OFF: on = 1'b0;
            MODE_ON: on = 1'b1;
            MODE_BLINK: on = blink_r;
            default: on = sel.vld[l] & fn_eval(sel.code[l], i_port_stat[p], blink_r);
          endcase
          stat_nxt[k] = on & emap_r[p];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ***************************************
  // Stream sequencer
  // ***************************************
  // One stream feeds both the serial pins and the parallel holding latch
  psl_sclk_state_t ph_r, ph_nxt;
  logic [7:0] half_r, half_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [NUM_IND-1:0] frame_r, frame_nxt, shift_r, shift_nxt, hold_r, hold_nxt;
  logic data_nxt, sclk_nxt;
  logic [NUM_IND-1:0] inv_mask;

  always_comb begin
    ph_nxt = ph_r;
    half_nxt = half_r + 8'h01;
    idx_nxt = idx_r;
    frame_nxt = frame_r;
    shift_nxt = shift_r;
    hold_nxt = hold_r;
    data_nxt = o_serial_indicator_data;
    if (half_r == 8'(SCLK_HALF - 1)) begin
      half_nxt = '0;
      case (ph_r)
        SH_LOW: begin
          ph_nxt = SH_HIGH;
          shift_nxt = {shift_r[NUM_IND-2:0], o_serial_indicator_data};
          if (idx_r == 4'(NUM_IND - 1)) begin
            hold_nxt = {shift_r[NUM_IND-2:0], o_serial_indicator_data};
          end
        end
        SH_HIGH: begin
          ph_nxt = SH_LOW;
          if (idx_r == 4'(NUM_IND - 1)) begin
            idx_nxt = '0;
            frame_nxt = stat_r;
            data_nxt = stat_r[NUM_IND-1];
          end else begin
            idx_nxt = idx_r + 4'h1;
            data_nxt = frame_r[4'(NUM_IND - 2) - idx_r];
          end
        end
        default: ph_nxt = SH_LOW;
      endcase
    end
    sclk_nxt = (ph_nxt == SH_HIGH) & cfg_r[CFG_SERIAL_BIT];
    // Dual pins whose strap read high are active low, those read low active high; all other pins active low
    inv_mask = {NUM_IND{1'b1}};
    inv_mask[DUAL_P4] = strap_r.mgmt_sel;
    inv_mask[DUAL_P3] = strap_r.hw_fwd;
    inv_mask[DUAL_P2] = strap_r.freq_hi;
    inv_mask[DUAL_P1] = strap_r.freq_lo;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ph_r <= SH_LOW;
      half_r <= '0;
      idx_r <= '0;
      frame_r <= '0;
      shift_r <= '0;
      hold_r <= '0;
      o_serial_indicator_data <= 1'b0;
      o_serial_indicator_clock <= 1'b0;
      o_ind <= {NUM_IND{1'b1}};
      o_ind_oe <= '0;
      o_strap <= psl_strap_t'(STRAP_RST);
      o_indicator_function_strap <= '0;
    end else begin
      ph_r <= ph_nxt;
      half_r <= half_nxt;
      idx_r <= idx_nxt;
      frame_r <= frame_nxt;
      shift_r <= shift_nxt;
      hold_r <= hold_nxt;
      o_serial_indicator_data <= data_nxt;
      o_serial_indicator_clock <= sclk_nxt;
      o_ind <= hold_r ^ inv_mask;
      o_ind_oe <= {NUM_IND{1'b1}};
      o_strap <= strap_r;
      o_indicator_function_strap <= fstrap_r;
    end
  end

  // ***************************************
  // Assertions
  // ***************************************
  live_reset_a: assert property (@(posedge i_ref_clk) $past(i_rst) |-> cfg_r[CFG_LIVE_BIT])
    else $error("live bit not set after reset");
  frozen_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !cfg_r[CFG_LIVE_BIT] && !i_wr |=> $stable(stat_r))
    else $error("frozen status changed");
  port_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    cfg_r[CFG_LIVE_BIT] && !emap_r[4] |=> stat_r[14:12] == 3'b000)
    else $error("disabled port shows status");
  ser_order_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ph_r == SH_HIGH |-> o_serial_indicator_data == frame_r[4'(NUM_IND - 1) - idx_r])
    else $error("serial bit out of order");
  ser_clk_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !cfg_r[CFG_SERIAL_BIT] |=> !o_serial_indicator_clock)
    else $error("shift clock runs in parallel mode");
  frame_wrap_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ph_r == SH_HIGH && idx_r == 4'(NUM_IND - 1) && half_r == 8'(SCLK_HALF - 1) |=> idx_r == 4'h0)
    else $error("frame did not restart");
  hold_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !(ph_r == SH_LOW && idx_r == 4'(NUM_IND - 1)) |=> $stable(hold_r))
    else $error("parallel hold changed mid frame");
  pin_polar_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !$past(i_rst) |-> o_ind[DUAL_P4] == ($past(hold_r[DUAL_P4]) ^ $past(strap_r.mgmt_sel)))
    else $error("dual pin polarity wrong");
  strap_keep_a: assert property (@(posedge i_ref_clk) !i_rst && !$past(i_rst) |-> $stable(strap_r))
    else $error("strap changed outside reset");
  oe_reset_a: assert property (@(posedge i_ref_clk) $past(i_rst) |-> o_ind_oe == '0)
    else $error("dual pins driven in reset");

  frame_done_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    ph_r == SH_LOW && idx_r == 4'(NUM_IND - 1) && half_r == 8'(SCLK_HALF - 1));
  serial_run_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(o_serial_indicator_clock));
  freeze_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) $fell(cfg_r[CFG_LIVE_BIT]));
  swsel_c: cover property (@(posedge i_ref_clk) disable iff (i_rst) cfg_r[CFG_SWSEL_BIT] && fmap_r[0]);

endmodule : psl_top
`default_nettype wire

/* File: sim/psl_chain_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ********
// External shift chain
// ********
module psl_chain_model (
  input wire logic i_sclk,
  input wire logic i_sdata,
  output var logic [14:0] o_shreg,
  output var int o_rises
);
  initial begin
    o_shreg = '0;
    o_rises = 0;
  end

  // No latch line exists, so the lamps see the chain as it shifts
  always @(posedge i_sclk) begin
    o_shreg <= {o_shreg[13:0], i_sdata};
    o_rises <= o_rises + 1;
  end
endmodule : psl_chain_model
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import psl_pkg::*;
  // ********
  // Bench
  // ********
  localparam logic [7:0] AD [7] = '{ADDR_CONFIG, ADDR_FUNC0, ADDR_FUNC1, ADDR_FMAP, ADDR_EMAP,
                                    ADDR_MODE0, ADDR_MODE1};
  localparam logic [15:0] SETS [4] = '{STRAP_SET0, STRAP_SET1, STRAP_SET2, STRAP_SET3};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  psl_port_stat_t [4:0] pstat = '0;
  logic [1:0] fs_s = 2'b00;
  logic [3:0] st_s = 4'hf;
  logic [14:0] pin, ind, oe, pull, shreg;
  logic sdata, sclk;
  psl_strap_t strap;
  logic [1:0] fstrap;
  logic [15:0] rv [7];
  int rises;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  always #50 clk = ~clk;
  // Pull pattern doubles as the polarity mask of the pins
  assign pull = {2'b11, st_s[3], 2'b11, st_s[2], 2'b11, st_s[1], 2'b11, st_s[0], 3'b111};
  assign pin = (ind & oe) | (pull & ~oe);

  psl_top #(.BLINK_HALF(8), .SCLK_HALF(4)) u_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_port_stat(pstat), .i_indicator_function_strap(fs_s), .i_ind_pin(pin),
    .o_ind(ind), .o_ind_oe(oe), .o_serial_indicator_data(sdata), .o_serial_indicator_clock(sclk),
    .o_strap(strap), .o_indicator_function_strap(fstrap));
  psl_chain_model u_chain (.i_sclk(sclk), .i_sdata(sdata), .o_shreg(shreg), .o_rises(rises));

  // ********
  // Tasks
  // ********
  task automatic finish_test();
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, rdata, e);
  endtask : rd_chk

  function automatic logic [14:0] exp_stat();
    logic [14:0] r;
    logic [15:0] bm;
    logic [1:0] md;
    int n;
    r = '0;
    for (int p = 0; p < 5; p++) begin
      bm = !rv[0][1] ? SETS[fs_s] : (rv[3][p] ? rv[2] : rv[1]);
      n = 0;
      for (int k = 0; k < 16; k++) begin
        if (bm[k] && n < 3) begin
          case (k)
            0, 2: r[p*3+2-n] = pstat[p].link;
            3: r[p*3+2-n] = pstat[p].link & pstat[p].duplex;
            4: r[p*3+2-n] = pstat[p].link & pstat[p].speed100;
            5: r[p*3+2-n] = pstat[p].link & ~pstat[p].speed100;
            default: r[p*3+2-n] = 1'b0;
          endcase
          n++;
        end
      end
      for (int b = 0; b < 3; b++) begin
        md = {rv[6][p*3+b], rv[5][p*3+b]};
        if (md == 2'b01 || !rv[4][p]) r[p*3+b] = 1'b0;
        else if (md == 2'b10) r[p*3+b] = 1'b1;
      end
    end
    return r;
  endfunction : exp_stat

  function automatic logic rot_ok(input logic [14:0] a, input logic [14:0] b);
    logic [29:0] d;
    d = {a, a};
    for (int r = 0; r < 15; r++) if (d[r +: 15] === b) return 1'b1;
    return 1'b0;
  endfunction : rot_ok

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    st_s <= 4'($urandom);
    fs_s <= 2'($urandom);
    repeat (20) @(posedge clk);
    #1;
    chk("oe_rst", {1'b0, oe}, 16'h0000);
    chk("ind_rst", {1'b0, ind}, 16'h7fff);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("oe_run", {1'b0, oe}, 16'h7fff);
    chk("strap", {10'h000, fstrap, strap}, {10'h000, fs_s, st_s});
    rv = '{{8'h00, CONFIG_RST}, FUNC_RST, FUNC_RST, FMAP_RST, EMAP_RST, MODE_RST, MODE_RST};
    for (int i = 0; i < 7; i++) rd_chk("reg_rst", AD[i], rv[i]);
    rd_chk("strap_reg", ADDR_STRAPS, {10'h000, fs_s, st_s});
  endtask : do_reset

  task automatic rand_stat();
    logic l;
    @(posedge clk);
    for (int p = 0; p < 5; p++) begin
      l = 1'($urandom);
      // Speed forced high without link keeps the speed-10 lamp unambiguous
      pstat[p] <= {l, 1'($urandom), l ? 1'($urandom) : 1'b1, 1'b0};
    end
  endtask : rand_stat

  task automatic settle_check();
    logic [14:0] e;
    int r0;
    r0 = rises;
    repeat (400) @(posedge clk);
    #1;
    e = exp_stat();
    chk("pins", {1'b0, ind}, {1'b0, e ^ pull});
    rd_chk("status", ADDR_STATUS, {1'b0, e});
    if (rv[0][0]) chk("frame", {15'h0000, rot_ok(shreg, e)}, 16'h0001);
    else chk("sclk_idle", 16'(rises - r0), 16'h0000);
  endtask : settle_check

  // ********
  // Sequence
  // ********
  initial begin
    logic [14:0] e;
    logic [1:0] seen;
    void'($urandom(32'h7ed4));
    for (int it = 0; it < 12; it++) begin
      if (it % 4 == 0) do_reset();
      rv[0] = {8'h00, 1'b1, 5'h00, 2'($urandom)};
      for (int i = 1; i < 7; i++) rv[i] = 16'($urandom);
      rv[1] &= 16'h00ff;
      rv[2] &= 16'h00ff;
      rv[3] &= 16'h001f;
      rv[4] = (it == 1) ? 16'h0000 : (it == 2) ? 16'h0015 : (rv[4] & 16'h001f);
      rv[6] &= 16'h7fff;
      rv[5] &= ~rv[6] & 16'h7fff;
      for (int i = 0; i < 7; i++) wr_reg(AD[i], rv[i]);
      for (int i = 0; i < 7; i++) rd_chk("reg", AD[i], rv[i]);
      rand_stat();
      settle_check();
    end
    wr_reg(ADDR_STATUS, 16'hffff);
    wr_reg(8'h11, 16'hffff);
    rd_chk("unmapped", 8'h11, 16'h0000);
    e = exp_stat();
    wr_reg(ADDR_CONFIG, rv[0] & 16'h007f);
    rand_stat();
    repeat (400) @(posedge clk);
    #1;
    chk("frozen", {1'b0, ind}, {1'b0, e ^ pull});
    rd_chk("frozen_st", ADDR_STATUS, {1'b0, e});
    wr_reg(ADDR_CONFIG, rv[0]);
    settle_check();
    // Activity alone on lamp A of every port
    @(posedge clk);
    pstat <= {5{4'b1001}};
    rv = '{16'h0082, 16'h0002, 16'h0000, 16'h0000, 16'h001f, 16'h0000, 16'h0000};
    for (int i = 0; i < 7; i++) wr_reg(AD[i], rv[i]);
    seen = 2'b00;
    repeat (600) begin
      @(posedge clk);
      #1;
      seen[ind[2]] = 1'b1;
    end
    chk("act_blink", {14'h0000, seen}, 16'h0003);
    rv[4] = 16'h001f;
    rv[5] = 16'h7fff;
    rv[6] = 16'h7fff;
    for (int i = 4; i < 7; i++) wr_reg(AD[i], rv[i]);
    seen = 2'b00;
    repeat (600) begin
      @(posedge clk);
      #1;
      seen[ind[0]] = 1'b1;
    end
    chk("blink", {14'h0000, seen}, 16'h0003);
    finish_test();
  end
endmodule : tb
`default_nettype wire
